// >>> logic/ccu_defs.vh
`ifndef CCU_DEFS_VH
`define CCU_DEFS_VH

// register byte offsets
`define CCU_ADDR_W 8
`define CCU_OFF_CTRL 8'h00
`define CCU_OFF_SAMP 8'h04
`define CCU_OFF_STAT 8'h08
`define CCU_OFF_CAP0 8'h0c
`define CCU_OFF_CAP1 8'h10
`define CCU_OFF_DIFF 8'h14

// control register fields
`define CCU_CTRL_W 12
`define CCU_CTRL_RST 12'h000
`define CCU_B_EN 0
`define CCU_B_CONT 1
`define CCU_B_SAMP 2
`define CCU_B_TSEL_LO 3
`define CCU_B_TSEL_HI 4
`define CCU_B_C0_SRC 5
`define CCU_B_C0_RISE 6
`define CCU_B_C0_FALL 7
`define CCU_B_C1_SRC 8
`define CCU_B_C1_RISE 9
`define CCU_B_C1_FALL 10
`define CCU_B_ERR_CONT 11

// sampling start trigger select
`define CCU_TSEL_C0_HI 2'h0
`define CCU_TSEL_C0_LO 2'h1
`define CCU_TSEL_EN 2'h2

// status register fields
`define CCU_B_ST_CAP0 0
`define CCU_B_ST_CAP1 1
`define CCU_B_ST_ERR 2
`define CCU_B_ST_STOP 3
`define CCU_B_ST_BUSY 4

// reset values
`define CCU_SAMP_RST 32'h0000_0001
`define CCU_ZERO32 32'h0000_0000

`endif

// >>> logic/ccu_in_sync.v
`timescale 1ns/1ns
module ccu_in_sync #(
   parameter N = 2
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // raw pins
   input wire [N-1:0] pin,
   // synchronised edges
   output wire [N-1:0] rise,
   output wire [N-1:0] fall
);
   reg [N-1:0] meta;
   reg [N-1:0] stable;
   reg [N-1:0] last;

   // edges only look at the second and third stages
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= {N{1'b0}};
         stable <= {N{1'b0}};
         last <= {N{1'b0}};
      end
      else
      begin
         meta <= pin;
         stable <= meta;
         last <= stable;
      end
   end

   assign rise = stable & ~last;
   assign fall = ~stable & last;
endmodule

// >>> logic/ccu_samp_timer.v
`timescale 1ns/1ns
module ccu_samp_timer #(
   parameter W = 32
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire start,
   input wire abort,
   input wire auto,
   input wire [W-1:0] len,
   // state
   output reg busy,
   output reg done
);
   reg [W-1:0] cnt;
   wire [W-1:0] load = (len == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : len;

   // a zero length still waits one cycle
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= {W{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (abort)
            busy <= 1'b0;
         else if (start && !busy)
         begin
            cnt <= load;
            busy <= 1'b1;
         end
         else if (busy)
         begin
            if (cnt == {{(W-1){1'b0}}, 1'b1})
            begin
               done <= 1'b1;
               busy <= auto;
               cnt <= load;
            end
            else
               cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// >>> logic/ccu_capture.v
// How it works
// R1: continuous mode captures every valid trigger
// R2: differential sign follows enable/trigger order
// R3: continuous mode overwrites both values and differential
// R4: one-shot sampling stores count and difference
// R5: sampling mode always armed, no enable
// R6: sampling start: input0 high, low, enable
// R7: one-shot sampling raises capture 1 status
// R8: continuous sampling raises capture 0 status
// R9: captures held as signed 32-bit values
// R10: completion reaches status at next refresh
// R11: ordinary mode: enable rise clears status
// R12: capture immediately on trigger, program-independent
// R13: refresh clears internal completion flag
// R14: frequent captures keep status bit asserted
// R15: overflow/underflow stop unless continue configured
// R16: ordinary triggers accepted only while enabled
// R17: either input may trigger either capture
// R18: sampling differential is interval count change
// R19: refresh is a one-cycle strobe
// R20: differential is capture1 minus capture0, wrapping
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "ccu_defs.vh"
module ccu_capture #(
   parameter CW = 32
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire [`CCU_ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // control input pins
   input wire ctrl_in0,
   input wire ctrl_in1,
   // counting core
   input wire [CW-1:0] count_value,
   input wire count_ovf,
   input wire count_udf,
   // controller refresh and status
   input wire io_refresh,
   output reg cap0_status,
   output reg cap1_status,
   output reg unit_error,
   output reg op_stop
);
   reg [`CCU_CTRL_W-1:0] ctrl;
   reg [CW-1:0] samp_len;
   reg signed [CW-1:0] cap0;
   reg signed [CW-1:0] cap1;
   reg signed [CW-1:0] diff;
   reg [CW-1:0] start_cnt;
   reg cap0_done;
   reg cap1_done;
   reg en_d;
   reg armed0;
   reg armed1;
   reg [31:0] rd_mux;
   reg rd_hit;

   wire [1:0] rise;
   wire [1:0] fall;
   wire samp_busy;
   wire samp_done;

   // pins are asynchronous; edges come only from the synchronised copies
   ccu_in_sync #(
      .N(2)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .pin({ctrl_in1, ctrl_in0}),
      .rise(rise),
      .fall(fall)
   );

   // selectable source and edge for one capture channel
   // both channels share this decode, so either pin feeds either capture
   function trig_hit;
      input src;
      input on_rise;
      input on_fall;
      input [1:0] r;
      input [1:0] f;
      begin
         trig_hit = (on_rise & r[src]) | (on_fall & f[src]);
      end
   endfunction

   wire en = ctrl[`CCU_B_EN];
   wire cont = ctrl[`CCU_B_CONT];
   wire samp_mode = ctrl[`CCU_B_SAMP];
   wire [1:0] tsel = ctrl[`CCU_B_TSEL_HI:`CCU_B_TSEL_LO];
   wire en_rise = en & ~en_d;
   wire run_ok = ~op_stop;

   // ordinary capture, gated by the enable request
   wire hit0 = ~samp_mode & en & (armed0 | en_rise) & run_ok &
      trig_hit(ctrl[`CCU_B_C0_SRC], ctrl[`CCU_B_C0_RISE], ctrl[`CCU_B_C0_FALL],
               rise, fall); // R16 R17 R12
   wire hit1 = ~samp_mode & en & (armed1 | en_rise) & run_ok &
      trig_hit(ctrl[`CCU_B_C1_SRC], ctrl[`CCU_B_C1_RISE], ctrl[`CCU_B_C1_FALL],
               rise, fall); // R16 R17 R12

   // sampling start needs no enable request
   // select code 3 leaves sampling without a start source
   wire samp_trig = (tsel == `CCU_TSEL_C0_HI) ? rise[0] :
                    (tsel == `CCU_TSEL_C0_LO) ? fall[0] :
                    (tsel == `CCU_TSEL_EN) ? en_rise : 1'b0; // R6
   wire samp_start = samp_mode & run_ok & samp_trig & ~samp_busy; // R5

   // continuous sampling reloads itself so no interval is lost
   // abort frees the timer once sampling mode ends or an error stops us
   ccu_samp_timer #(
      .W(CW)
   ) u_timer (
      .clk(pclk),
      .rst_n(presetn),
      .start(samp_start),
      .abort(~samp_mode | op_stop),
      .auto(cont),
      .len(samp_len),
      .busy(samp_busy),
      .done(samp_done)
   );

   wire ev0 = hit0 | (samp_done & cont); // R8
   wire ev1 = hit1 | (samp_done & ~cont); // R7
   wire clr_ord = en_rise & ~samp_mode;

   // arming for one-shot ordinary capture
   // a trigger in the enable's own cycle already counts
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_d <= 1'b0;
         armed0 <= 1'b0;
         armed1 <= 1'b0;
      end
      else
      begin
         en_d <= en;
         if (!en)
         begin
            armed0 <= 1'b0;
            armed1 <= 1'b0;
         end
         else
         begin
            armed0 <= (armed0 | en_rise) & ~(hit0 & ~cont); // R1
            armed1 <= (armed1 | en_rise) & ~(hit1 & ~cont); // R1
         end
      end
   end

   // capture values; differential wraps in 32 bits
   // sampling mode blocks ordinary hits; a completion in the cycle sampling mode ends wins over them
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap0 <= `CCU_ZERO32;
         cap1 <= `CCU_ZERO32;
         diff <= `CCU_ZERO32;
         start_cnt <= `CCU_ZERO32;
      end
      else
      begin
         if (samp_start || (samp_done && cont))
            start_cnt <= count_value;
         if (samp_done)
         begin
            cap0 <= count_value; // R4 R3
            cap1 <= count_value; // R4 R3
            diff <= count_value - start_cnt; // R18 R9
         end
         else
         begin
            if (hit0)
               cap0 <= count_value; // R3 R9
            if (hit1)
               cap1 <= count_value; // R3 R9
            // a side captured now contributes its new value
            if (hit0 || hit1)
               diff <= (hit1 ? count_value : cap1) - (hit0 ? count_value : cap0); // R20 R2
         end
      end
   end

   // completion flags: a new event wins over the clear
   // enable rise in ordinary mode drops completions left from before it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap0_done <= 1'b0;
         cap1_done <= 1'b0;
         cap0_status <= 1'b0;
         cap1_status <= 1'b0;
      end
      else
      begin
         cap0_done <= ev0 | (cap0_done & ~io_refresh & ~clr_ord); // R13 R19
         cap1_done <= ev1 | (cap1_done & ~io_refresh & ~clr_ord); // R13 R19
         if (clr_ord)
         begin
            cap0_status <= 1'b0; // R11
            cap1_status <= 1'b0; // R11
         end
         else if (io_refresh)
         begin
            cap0_status <= cap0_done; // R10 R14
            cap1_status <= cap1_done; // R10 R14
         end
      end
   end

   // apb: answer one cycle into the access phase
   // one wait state lets read data come straight from a register
   wire acc = psel & penable & ~pready;
   wire commit = psel & penable & pready & pwrite;
   wire err_clr = commit & (paddr == `CCU_OFF_STAT) & pwdata[`CCU_B_ST_ERR];
   wire err_evt = count_ovf | count_udf;

   // unmapped offsets read zero and raise a slave error
   always @*
   begin
      rd_mux = `CCU_ZERO32;
      rd_hit = 1'b1;
      if (paddr == `CCU_OFF_CTRL)
         rd_mux[`CCU_CTRL_W-1:0] = ctrl;
      else if (paddr == `CCU_OFF_SAMP)
         rd_mux = samp_len;
      else if (paddr == `CCU_OFF_STAT)
      begin
         rd_mux[`CCU_B_ST_CAP0] = cap0_status;
         rd_mux[`CCU_B_ST_CAP1] = cap1_status;
         rd_mux[`CCU_B_ST_ERR] = unit_error;
         rd_mux[`CCU_B_ST_STOP] = op_stop;
         rd_mux[`CCU_B_ST_BUSY] = samp_busy;
      end
      else if (paddr == `CCU_OFF_CAP0)
         rd_mux = cap0;
      else if (paddr == `CCU_OFF_CAP1)
         rd_mux = cap1;
      else if (paddr == `CCU_OFF_DIFF)
         rd_mux = diff;
      else
         rd_hit = 1'b0;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `CCU_ZERO32;
         ctrl <= `CCU_CTRL_RST;
         samp_len <= `CCU_SAMP_RST;
      end
      else
      begin
         pready <= acc;
         if (acc)
         begin
            prdata <= pwrite ? `CCU_ZERO32 : rd_mux;
            pslverr <= ~rd_hit;
         end
         else if (!psel)
         begin
            pslverr <= 1'b0;
         end
         if (commit && paddr == `CCU_OFF_CTRL)
            ctrl <= pwdata[`CCU_CTRL_W-1:0];
         if (commit && paddr == `CCU_OFF_SAMP)
            samp_len <= pwdata;
      end
   end

   // errors stop capture unless configured to continue
   // op_stop moves with unit_error, so no capture slips in between
   // limitation: a stop aborts a running sampling interval
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit_error <= 1'b0;
         op_stop <= 1'b0;
      end
      else
      begin
         unit_error <= err_evt | (unit_error & ~err_clr); // R15
         op_stop <= (err_evt | (unit_error & ~err_clr)) & ~ctrl[`CCU_B_ERR_CONT]; // R15
      end
   end
endmodule

// >>> bench/ccu_capture_monitor.sv
`timescale 1ns/1ns
module ccu_capture_monitor (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // counting core and refresh
   input wire count_ovf,
   input wire count_udf,
   input wire io_refresh,
   // status
   input wire cap0_status,
   input wire cap1_status,
   input wire unit_error,
   input wire op_stop
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   a_ready_wait: assert property (s_wait |=> pready)
      else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_map: assert property (s_done ##0 paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
      else $error("bad slave error");
   a_wr_zero: assert property (s_done ##0 pwrite |-> prdata == 32'h0)
      else $error("read data on write");
   a_stat0_refresh: assert property ($rose(cap0_status) |-> $past(io_refresh))
      else $error("status 0 without refresh");
   a_stat1_refresh: assert property ($rose(cap1_status) |-> $past(io_refresh))
      else $error("status 1 without refresh");
   a_err_event: assert property ((count_ovf || count_udf) |=> unit_error)
      else $error("error missed");
   a_err_sticky: assert property (unit_error && !(psel && pready && pwrite &&
      paddr == 8'h08) |=> unit_error)
      else $error("error dropped");
   a_stop_cause: assert property ($rose(op_stop) |-> unit_error)
      else $error("stop without error");
endmodule
bind ccu_capture ccu_capture_monitor ccu_capture_monitor_i (.pclk, .presetn, .paddr, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .count_ovf, .count_udf, .io_refresh,
   .cap0_status, .cap1_status, .unit_error, .op_stop);

// >>> bench/ccu_trigger_src.sv
`timescale 1ns/1ns
module ccu_trigger_src (
   // clock
   input wire pclk,
   // requested levels and answer delay
   input wire [1:0] want,
   input wire [3:0] lag,
   // pins
   output logic ctrl_in0,
   output logic ctrl_in1
);
   logic [1:0] dly [0:15];
   integer k;
   // pins follow want after a delay selected by lag, unrelated to register traffic
   always @(posedge pclk)
   begin
      dly[0] <= want;
      for (k = 1; k < 16; k++)
         dly[k] <= dly[k-1];
      {ctrl_in1, ctrl_in0} <= dly[lag];
   end
endmodule

// >>> bench/counter_capture_unit_bench.sv
`timescale 1ns/1ns
module counter_capture_unit_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic count_ovf = 0, count_udf = 0, io_refresh = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, count_value = 0, v0, v1, seed = 32'h232415aa;
   logic [1:0] want = 0;
   logic [3:0] lag = 1;
   logic [95:0] expq [$];
   logic [95:0] e;
   wire [31:0] prdata;
   wire pready, pslverr, ctrl_in0, ctrl_in1, cap0_status, cap1_status, unit_error, op_stop;
   integer bad_count = 0, compares = 0, i;
   always #2 pclk = ~pclk;
   ccu_capture ccu_capture_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .ctrl_in0, .ctrl_in1, .count_value, .count_ovf, .count_udf,
      .io_refresh, .cap0_status, .cap1_status, .unit_error, .op_stop);
   ccu_trigger_src ccu_trigger_src_i (.pclk, .want, .lag, .ctrl_in0, .ctrl_in1);
   function logic [31:0] rnd(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task complete_run;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task wt(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [95:0] x);
      integer n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      if (!w)
         expq.push_back(x);
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (n >= 9)
      begin
         bad_count++;
         complete_run;
      end
      else
      begin
         psel <= 0;
         penable <= 0;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(0, a, 0, {m, x, 32'h0});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d, 96'h0);
   endtask
   task pin(input logic [1:0] v);
      want <= v;
      wt(lag + 8);
   endtask
   task refresh;
      @(posedge pclk);
      io_refresh <= 1;
      @(posedge pclk);
      io_refresh <= 0;
      wt(1);
   endtask
   // read results checked in arrival order
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      begin
         e = expq.pop_front();
         chk(prdata & e[95:64], e[63:32]);
         chk(pslverr, e[31:0]);
      end
   initial
   begin
      #200000;
      bad_count++;
      complete_run;
   end
   initial
   begin
      wt(8);
      presetn <= 1;
      rd(8'h00, '1, 0);
      rd(8'h04, '1, 1);
      rd(8'h08, '1, 0);
      rd(8'h14, '1, 0);
      apb(0, 8'h18, 0, {32'h0, 32'h0, 32'h1});
      $display("test 1 done");
      wr(8'h00, 32'h341);
      seed = rnd(seed);
      v0 = seed;
      count_value <= v0;
      pin(2'b01);
      seed = rnd(seed);
      v1 = seed;
      count_value <= v1;
      pin(2'b11);
      count_value <= 5;
      pin(2'b00);
      pin(2'b01);
      rd(8'h0c, '1, v0);
      rd(8'h10, '1, v1);
      rd(8'h14, '1, v1 - v0);
      rd(8'h08, 3, 0);
      refresh;
      chk(cap0_status, 1);
      chk(cap1_status, 1);
      wr(8'h00, 32'h342);
      pin(2'b00);
      pin(2'b01);
      rd(8'h0c, '1, v0);
      wr(8'h00, 32'h3c3);
      rd(8'h08, 3, 0);
      $display("test 2 done");
      lag <= 9;
      wt(1);
      for (i = 0; i < 4; i++)
      begin
         seed = rnd(seed);
         count_value <= seed;
         pin({1'b0, i[0]});
         rd(8'h0c, '1, seed);
         rd(8'h14, '1, v1 - seed);
         refresh;
         chk(cap0_status, 1);
      end
      refresh;
      chk(cap0_status, 0);
      // crossed mapping: capture 0 from pin 1 rise, capture 1 from pin 0 fall
      wr(8'h00, 32'h463);
      seed = rnd(seed);
      v0 = seed;
      count_value <= v0;
      pin(2'b11);
      seed = rnd(seed);
      v1 = seed;
      count_value <= v1;
      pin(2'b10);
      rd(8'h0c, '1, v0);
      rd(8'h10, '1, v1);
      rd(8'h14, '1, v1 - v0);
      lag <= 1;
      $display("test 3 done");
      wr(8'h04, 12);
      for (i = 0; i < 3; i++)
      begin
         wr(8'h00, 0);
         pin({1'b0, i == 1});
         refresh;
         refresh;
         seed = rnd(seed);
         v0 = seed;
         count_value <= v0;
         wr(8'h00, 4 | (i << 3) | (i == 2 ? 3 : 0));
         want <= {1'b0, i == 0};
         wt(lag + 6);
         seed = rnd(seed);
         v1 = seed;
         count_value <= v1;
         wt(40);
         rd(8'h0c, '1, v1);
         rd(8'h10, '1, v1);
         rd(8'h14, '1, i == 2 ? 0 : v1 - v0);
         refresh;
         rd(8'h08, 3, i == 2 ? 1 : 2);
         rd(8'h08, 32'h10, i == 2 ? 32'h10 : 0);
      end
      wr(8'h00, 0);
      $display("test 4 done");
      count_ovf <= 1;
      wt(1);
      count_ovf <= 0;
      wt(3);
      chk(unit_error, 1);
      chk(op_stop, 1);
      wr(8'h08, 4);
      wt(3);
      chk(unit_error, 0);
      chk(op_stop, 0);
      wr(8'h00, 32'h800);
      count_udf <= 1;
      wt(1);
      count_udf <= 0;
      wt(3);
      chk(unit_error, 1);
      chk(op_stop, 0);
      $display("test 5 done");
      complete_run;
   end
endmodule
